// ### rtl/acc_pkg.sv
package acc_pkg;

	// ----------------------------------------------------------------
	// Command framing
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_READ        = 8'h08;
	localparam logic [7:0] CMD_WRITE       = 8'h09;
	localparam logic [7:0] LEN_READ        = 8'h03;
	localparam logic [7:0] LEN_WRITE_INDEX = 8'h03;
	localparam logic [7:0] LEN_WRITE_VALUE = 8'h04;
	localparam logic [7:0] ADDR_DATA       = 8'h69;
	localparam logic [7:0] ADDR_INDEX      = 8'h68;
	localparam logic [7:0] REG_SIZE_ONE    = 8'h01;
	localparam logic [7:0] FLAG_NO_INC     = 8'h00;
	localparam logic [7:0] FLAG_INC        = 8'h01;
	localparam logic [7:0] INDEX_TUNING    = 8'h04;
	localparam logic [7:0] INDEX_RESET     = 8'h00;
	localparam logic [7:0] INDEX_STEP      = 8'h01;

	// Parameter byte positions after code and length
	localparam int         MAX_PARAMS      = 4;
	localparam logic [1:0] P_ADDR          = 2'h0;
	localparam logic [1:0] P_SIZE_FLAG     = 2'h1;
	localparam logic [1:0] P_RSVD_INDEX    = 2'h2;
	localparam logic [1:0] P_VALUE         = 2'h3;

	// ----------------------------------------------------------------
	// Replies
	// ----------------------------------------------------------------
	localparam logic [7:0] RESULT_OK       = 8'h00;
	localparam logic [7:0] ERR_LENGTH      = 8'h82;
	localparam logic [7:0] ERR_PARAM       = 8'h82;
	localparam logic [7:0] LEN_NONE        = 8'h00;
	localparam logic [7:0] LEN_ONE         = 8'h01;
	localparam logic [7:0] READ_UNMAPPED   = 8'h00;
	localparam logic [1:0] REPLY_SHORT     = 2'h2;
	localparam logic [1:0] REPLY_LONG      = 2'h3;

	// ----------------------------------------------------------------
	// Tuning register layout
	// ----------------------------------------------------------------
	localparam logic [7:0] TUNING_DEFAULT  = 8'h27;
	localparam logic [7:0] RESERVED_MASK   = 8'hC0;
	localparam int         SENS_MSB        = 5;
	localparam int         SENS_LSB        = 4;
	localparam int         LMI_MSB         = 3;
	localparam int         LMI_LSB         = 0;

endpackage

// ### rtl/frame_collector.sv
module frame_collector
	import acc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  cmd_byte,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic        frame_taken,
	output logic             frame_valid,
	output logic [7:0]       frame_code,
	output logic [7:0]       frame_len,
	output logic [31:0]      frame_params
);

	typedef enum logic [1:0] {
		c_code,
		c_len,
		c_params,
		c_hold
	} collect_state_t;

	collect_state_t state;
	collect_state_t next_state;
	logic [7:0]     count;
	logic           accept;

	assign accept      = cmd_valid && cmd_ready;
	assign frame_valid = (state == c_hold);

	always_comb begin
		next_state = state;
		unique case (state)
			c_code: begin
				if (accept)
					next_state = c_len;
			end
			c_len: begin
				if (accept)
					next_state = (cmd_byte == LEN_NONE) ? c_hold : c_params;
			end
			c_params: begin
				if (accept && (8'(count + 8'h01) == frame_len))
					next_state = c_hold;
			end
			c_hold: begin
				if (frame_taken)
					next_state = c_code;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state     <= c_code;
			cmd_ready <= 1'b0;
		end else begin
			state     <= next_state;
			// No byte is taken while a frame waits for its reply
			cmd_ready <= (next_state != c_hold);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_code   <= 8'h00;
			frame_len    <= 8'h00;
			frame_params <= 32'h0000_0000;
			count        <= 8'h00;
		end else if (accept) begin
			unique case (state)
				c_code: frame_code <= cmd_byte;
				c_len: begin
					frame_len    <= cmd_byte;
					frame_params <= 32'h0000_0000;
					count        <= 8'h00;
				end
				c_params: begin
					// Bytes beyond the fourth are consumed but not kept
					if (count < 8'(MAX_PARAMS))
						frame_params[count[1:0]*8 +: 8] <= cmd_byte;
					count <= 8'(count + 8'h01);
				end
				c_hold: ;
			endcase
		end
	end

endmodule

// ### rtl/reply_sender.sv
module reply_sender
	import acc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        reply_load,
	input  wire logic [1:0]  reply_count,
	input  wire logic [7:0]  reply_b0,
	input  wire logic [7:0]  reply_b1,
	input  wire logic [7:0]  reply_b2,
	output logic [7:0]       rsp_byte,
	output logic             rsp_valid,
	input  wire logic        rsp_ready
);

	logic [7:0] hold1;
	logic [7:0] hold2;
	logic [1:0] left;

	// Bytes shift toward the output; left counts bytes still to follow the one shown
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_byte  <= 8'h00;
			rsp_valid <= 1'b0;
			hold1     <= 8'h00;
			hold2     <= 8'h00;
			left      <= 2'h0;
		end else if (reply_load && !rsp_valid) begin
			rsp_byte  <= reply_b0;
			rsp_valid <= 1'b1;
			hold1     <= reply_b1;
			hold2     <= reply_b2;
			left      <= 2'(reply_count - 2'h1);
		end else if (rsp_valid && rsp_ready) begin
			if (left == 2'h0) begin
				rsp_valid <= 1'b0;
			end else begin
				rsp_byte <= hold1;
				hold1    <= hold2;
				left     <= 2'(left - 2'h1);
			end
		end
	end

endmodule

// ### rtl/analog_config_register_access.sv
module analog_config_register_access
	import acc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  cmd_byte,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	output logic [7:0]       rsp_byte,
	output logic             rsp_valid,
	input  wire logic        rsp_ready,
	input  wire logic        protocol_choice_request,
	output logic [1:0]       demod_sensitivity,
	output logic [3:0]       load_mod_index,
	output logic [7:0]       index_pointer
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] param_at(
		input logic [31:0] params,
		input logic [1:0]  pos
	);
		param_at = params[pos*8 +: 8];
	endfunction

	function automatic logic flag_legal(input logic [7:0] flag);
		flag_legal = (flag == FLAG_NO_INC) || (flag == FLAG_INC);
	endfunction

	// ----------------------------------------------------------------
	// Frame intake
	// ----------------------------------------------------------------
	logic        frame_valid;
	logic [7:0]  frame_code;
	logic [7:0]  frame_len;
	logic [31:0] frame_params;
	logic        exec;

	frame_collector u_collect (
		.sys_clk      (sys_clk),
		.reset_n      (reset_n),
		.cmd_byte     (cmd_byte),
		.cmd_valid    (cmd_valid),
		.cmd_ready    (cmd_ready),
		.frame_taken  (exec),
		.frame_valid  (frame_valid),
		.frame_code   (frame_code),
		.frame_len    (frame_len),
		.frame_params (frame_params)
	);

	// ----------------------------------------------------------------
	// Decode and execute
	// ----------------------------------------------------------------
	logic [7:0] tuning;
	logic [7:0] p_addr;
	logic [7:0] p_size_flag;
	logic [7:0] p_rsvd_index;
	logic [7:0] p_value;
	logic [7:0] read_data;
	logic       reply_load;
	logic [1:0] reply_count;
	logic [7:0] reply_b0;
	logic [7:0] reply_b1;
	logic [7:0] reply_b2;
	logic       index_load;
	logic [7:0] index_new;
	logic       value_store;
	logic [7:0] value_new;
	logic       sender_busy;

	assign p_addr       = param_at(frame_params, P_ADDR);
	assign p_size_flag  = param_at(frame_params, P_SIZE_FLAG);
	assign p_rsvd_index = param_at(frame_params, P_RSVD_INDEX);
	assign p_value      = param_at(frame_params, P_VALUE);

	// One frame is handled per reply; a waiting reply stalls the next
	assign sender_busy = rsp_valid;
	assign exec        = frame_valid && !sender_busy;

	// Only index 04 is backed; other indices read as zero
	assign read_data = (index_pointer == INDEX_TUNING) ?
		tuning : READ_UNMAPPED;

	always_comb begin
		reply_load  = 1'b0;
		reply_count = REPLY_SHORT;
		reply_b0    = RESULT_OK;
		reply_b1    = LEN_NONE;
		reply_b2    = READ_UNMAPPED;
		index_load  = 1'b0;
		index_new   = index_pointer;
		value_store = 1'b0;
		value_new   = tuning;
		if (exec) begin
			unique case (frame_code)
				CMD_READ: begin
					reply_load = 1'b1;
					if (frame_len != LEN_READ) begin
						reply_b0 = ERR_LENGTH;
						reply_b1 = LEN_NONE;
					end else if ((p_addr != ADDR_DATA) ||
						(p_size_flag != REG_SIZE_ONE)) begin
						reply_b0 = ERR_PARAM;
					end else begin
						reply_count = REPLY_LONG;
						reply_b0    = RESULT_OK;
						reply_b1    = LEN_ONE;
						reply_b2    = read_data;
					end
				end
				CMD_WRITE: begin
					reply_load = 1'b1;
					if ((frame_len != LEN_WRITE_INDEX) &&
						(frame_len != LEN_WRITE_VALUE)) begin
						reply_b0 = ERR_LENGTH;
						reply_b1 = LEN_NONE;
					end else if ((p_addr != ADDR_INDEX) ||
						!flag_legal(p_size_flag)) begin
						reply_b0 = ERR_PARAM;
					end else begin
						reply_b0   = RESULT_OK;
						reply_b1   = LEN_NONE;
						index_load = 1'b1;
						index_new  = p_rsvd_index;
						if (frame_len == LEN_WRITE_VALUE) begin
							if (p_rsvd_index == INDEX_TUNING) begin
								value_store = 1'b1;
								value_new   = p_value;
							end
							// Auto-increment moves past the byte just written
							if (p_size_flag == FLAG_INC)
								index_new = 8'(p_rsvd_index + INDEX_STEP);
						end
					end
				end
				// Frames of other commands are dropped without a reply
				default: reply_load = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Index pointer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			index_pointer <= INDEX_RESET;
		else if (index_load)
			index_pointer <= index_new;
	end

	// ----------------------------------------------------------------
	// Tuning register
	// ----------------------------------------------------------------
	// Reset stands for power-up, so nothing survives it; defaults load
	// as if a protocol choice had just been made.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			tuning <= TUNING_DEFAULT;
		else if (value_store)
			// A write in the same cycle as a protocol choice wins
			tuning <= value_new & ~RESERVED_MASK;
		else if (protocol_choice_request)
			tuning <= TUNING_DEFAULT;
	end

	// Fields are passed on raw: the 10 percent code is not settled, so
	// no decoding is done here.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			demod_sensitivity <= TUNING_DEFAULT[SENS_MSB:SENS_LSB];
			load_mod_index    <= TUNING_DEFAULT[LMI_MSB:LMI_LSB];
		end else if (value_store) begin
			demod_sensitivity <= value_new[SENS_MSB:SENS_LSB];
			load_mod_index    <= value_new[LMI_MSB:LMI_LSB];
		end else if (protocol_choice_request) begin
			demod_sensitivity <= TUNING_DEFAULT[SENS_MSB:SENS_LSB];
			load_mod_index    <= TUNING_DEFAULT[LMI_MSB:LMI_LSB];
		end
	end

	// ----------------------------------------------------------------
	// Reply output
	// ----------------------------------------------------------------
	reply_sender u_reply (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.reply_load  (reply_load),
		.reply_count (reply_count),
		.reply_b0    (reply_b0),
		.reply_b1    (reply_b1),
		.reply_b2    (reply_b2),
		.rsp_byte    (rsp_byte),
		.rsp_valid   (rsp_valid),
		.rsp_ready   (rsp_ready)
	);

endmodule

// ### tb/acc_properties.sv
module acc_properties
	import acc_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       reset_n,
	input wire logic [7:0] cmd_byte,
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire logic [7:0] rsp_byte,
	input wire logic       rsp_valid,
	input wire logic       rsp_ready,
	input wire logic       protocol_choice_request,
	input wire logic [1:0] demod_sensitivity,
	input wire logic [3:0] load_mod_index,
	input wire logic [7:0] index_pointer
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wire       acc  = cmd_valid && cmd_ready;
	wire [5:0] tune = {demod_sensitivity, load_mod_index};
	wire [5:0] low6 = cmd_byte[5:0];

	// ----------------------------------------------------------------
	// Frame shapes
	// ----------------------------------------------------------------
	// Last byte demands an idle reply path, so timing is not skewed
	sequence s_read;
		acc && cmd_byte == CMD_READ ##1 acc && cmd_byte == LEN_READ
		##1 acc && cmd_byte == ADDR_DATA ##1 acc && cmd_byte == REG_SIZE_ONE
		##1 acc && cmd_byte == 8'h00 && !rsp_valid;
	endsequence
	sequence s_wr_hdr(logic [7:0] len);
		acc && cmd_byte == CMD_WRITE ##1 acc && cmd_byte == len
		##1 acc && cmd_byte == ADDR_INDEX ##1 acc && cmd_byte == FLAG_NO_INC;
	endsequence
	sequence s_bad_len;
		acc && cmd_byte == CMD_WRITE ##1 acc && cmd_byte == 8'h02
		##1 acc ##1 acc && !rsp_valid;
	endsequence

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_reset_load;
		$rose(reset_n) |-> tune == TUNING_DEFAULT[5:0] && index_pointer == 8'h00;
	endproperty
	property p_rsp_hold;
		rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte);
	endproperty
	property p_default_load;
		protocol_choice_request && cmd_ready |=> tune == TUNING_DEFAULT[5:0];
	endproperty
	property p_tune_hold;
		cmd_ready && !protocol_choice_request |=> $stable(tune);
	endproperty
	property p_read_ok;
		s_read |-> ##2 rsp_valid && rsp_byte == RESULT_OK;
	endproperty
	property p_wr_index;
		s_wr_hdr(LEN_WRITE_INDEX) ##1 acc && !rsp_valid |-> ##2
			index_pointer == $past(cmd_byte, 2) && rsp_byte == RESULT_OK;
	endproperty
	property p_wr_value;
		s_wr_hdr(LEN_WRITE_VALUE) ##1 acc && cmd_byte == INDEX_TUNING
		##1 acc && !rsp_valid |-> ##2 tune == $past(low6, 2);
	endproperty
	property p_len_err;
		s_bad_len |-> ##2 rsp_valid && rsp_byte == ERR_LENGTH;
	endproperty
	property p_no_access;
		s_bad_len |=> $stable(index_pointer) [*3];
	endproperty

	a_reset_load: assert property (p_reset_load)
		else $error("tuning or index not at reset value");
	a_rsp_hold: assert property (p_rsp_hold)
		else $error("reply byte dropped before taken");
	a_default_load: assert property (p_default_load)
		else $error("protocol choice did not load default");
	a_tune_hold: assert property (p_tune_hold)
		else $error("tuning changed without cause");
	a_read_ok: assert property (p_read_ok)
		else $error("read reply missing or wrong code");
	a_wr_index: assert property (p_wr_index)
		else $error("index write not applied");
	a_wr_value: assert property (p_wr_value)
		else $error("tuning store not applied");
	a_len_err: assert property (p_len_err)
		else $error("length error not reported");
	a_no_access: assert property (p_no_access)
		else $error("bad frame changed index");
endmodule

bind analog_config_register_access acc_properties u_props (
	.sys_clk(sys_clk), .reset_n(reset_n), .cmd_byte(cmd_byte),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_byte(rsp_byte),
	.rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
	.protocol_choice_request(protocol_choice_request),
	.demod_sensitivity(demod_sensitivity),
	.load_mod_index(load_mod_index), .index_pointer(index_pointer)
);

// ### tb/host_model.sv
module host_model (
	input  wire logic       sys_clk,
	output logic [7:0]      cmd_byte,
	output logic            cmd_valid,
	input  wire logic       cmd_ready,
	input  wire logic [7:0] rsp_byte,
	input  wire logic       rsp_valid,
	output logic            rsp_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	int stall = 0;

	initial begin
		cmd_byte = 8'h00;
		cmd_valid = 1'b0;
		rsp_ready = 1'b0;
	end

	// Whole frame, held until taken; idle bus shows the inverted last byte
	task automatic send(input logic [7:0] f[$]);
		foreach (f[i]) begin
			cmd_valid <= 1'b1;
			cmd_byte <= f[i];
			do @(posedge sys_clk); while (!cmd_ready);
		end
		cmd_valid <= 1'b0;
		cmd_byte <= ~f[f.size()-1];
	endtask

	// Slow mode keeps ready low for stall cycles before each byte
	task automatic recv(input int n, output logic [7:0] r[$]);
		r = {};
		repeat (n) begin
			repeat (stall) @(posedge sys_clk);
			rsp_ready <= 1'b1;
			do @(posedge sys_clk); while (!rsp_valid);
			r.push_back(rsp_byte);
			if (stall > 0) rsp_ready <= 1'b0;
		end
		if (stall == 0) rsp_ready <= 1'b0;
	endtask
endmodule

// ### tb/analog_config_register_access_tb.sv
module analog_config_register_access_tb
	import acc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       sys_clk, reset_n, pcr, cmd_valid, cmd_ready;
	logic       rsp_valid, rsp_ready;
	logic [7:0] cmd_byte, rsp_byte, index_pointer, r[$];
	logic [1:0] demod_sensitivity;
	logic [3:0] load_mod_index;
	int         n_mismatch = 0;
	int         n_tests = 0;

	analog_config_register_access u_dut (.sys_clk(sys_clk),
		.reset_n(reset_n), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .rsp_byte(rsp_byte), .rsp_valid(rsp_valid),
		.rsp_ready(rsp_ready), .protocol_choice_request(pcr),
		.demod_sensitivity(demod_sensitivity),
		.load_mod_index(load_mod_index), .index_pointer(index_pointer));
	host_model u_host (.sys_clk(sys_clk), .cmd_byte(cmd_byte),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_byte(rsp_byte),
		.rsp_valid(rsp_valid), .rsp_ready(rsp_ready));

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [7:0] f[$], input logic [7:0] e[$]);
		u_host.send(f);
		u_host.recv(e.size(), r);
		foreach (e[i]) check(r[i], e[i]);
	endtask
	task automatic rd(input logic [7:0] d);
		xfer({CMD_READ, LEN_READ, ADDR_DATA, REG_SIZE_ONE, 8'h00},
			{RESULT_OK, LEN_ONE, d});
	endtask
	task automatic wr(input logic [7:0] fl, ix, v, input bit four);
		if (four) xfer({CMD_WRITE, LEN_WRITE_VALUE, ADDR_INDEX, fl, ix, v},
			{RESULT_OK, LEN_NONE});
		else xfer({CMD_WRITE, LEN_WRITE_INDEX, ADDR_INDEX, fl, ix},
			{RESULT_OK, LEN_NONE});
	endtask
	task automatic tun(input logic [7:0] exp);
		check({2'b00, demod_sensitivity, load_mod_index}, exp);
	endtask
	task automatic results();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, reset, watchdog
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Tests need about 250 cycles; some eighty times that means a hang
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		results();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		pcr = 1'b0;
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		tun(TUNING_DEFAULT);
		pcr <= 1'b1;
		@(posedge sys_clk);
		pcr <= 1'b0;
		rd(READ_UNMAPPED);
		wr(FLAG_NO_INC, INDEX_TUNING, 8'h00, 0);
		check(index_pointer, INDEX_TUNING);
		rd(TUNING_DEFAULT);
		$display("test read path done");
		u_host.stall = 3;
		wr(FLAG_NO_INC, INDEX_TUNING, 8'h25, 1);
		rd(8'h25);
		for (int s = 0; s < 4; s++) begin
			logic [7:0] v;
			v = {2'h0, 2'(s), s[0] ? 4'hF : 4'h1};
			wr(FLAG_NO_INC, INDEX_TUNING, v, 1);
			tun(v);
		end
		u_host.stall = 0;
		wr(FLAG_INC, INDEX_TUNING, 8'h17, 1);
		check(index_pointer, 8'h05);
		rd(READ_UNMAPPED);
		wr(FLAG_NO_INC, INDEX_TUNING, 8'h00, 0);
		$display("test write path done");
		xfer({CMD_READ, 8'h02, ADDR_DATA, REG_SIZE_ONE},
			{ERR_LENGTH, LEN_NONE});
		xfer({CMD_WRITE, 8'h02, ADDR_INDEX, 8'h07},
			{ERR_LENGTH, LEN_NONE});
		xfer({CMD_WRITE, 8'h05, ADDR_INDEX, 8'h00, INDEX_TUNING, 8'h11,
			8'h22}, {ERR_LENGTH, LEN_NONE});
		xfer({CMD_READ, LEN_READ, ADDR_INDEX, REG_SIZE_ONE, 8'h00},
			{ERR_PARAM, LEN_NONE});
		xfer({CMD_WRITE, LEN_WRITE_VALUE, ADDR_INDEX, 8'h02, INDEX_TUNING,
			8'h11}, {ERR_PARAM, LEN_NONE});
		u_host.send({8'h07, 8'h00});
		repeat (4) @(posedge sys_clk);
		check({7'h00, rsp_valid}, 8'h00);
		check(index_pointer, INDEX_TUNING);
		tun(8'h17);
		$display("test length errors done");
		@(posedge sys_clk);
		pcr <= 1'b1;
		@(posedge sys_clk);
		pcr <= 1'b0;
		@(posedge sys_clk);
		tun(TUNING_DEFAULT);
		rd(TUNING_DEFAULT);
		$display("test protocol choice done");
		wr(FLAG_NO_INC, INDEX_TUNING, 8'h3A, 1);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		tun(TUNING_DEFAULT);
		check(index_pointer, INDEX_RESET);
		$display("test power loss done");
		results();
	end
endmodule
